//--- i2cis_pkg.sv
/*
 * Shared constants for the two-wire interrupt status block: register
 * addresses, status bit positions, reset values, FIFO sizes, enable modes.
 * Assumes a 32-bit register address space and a single system clock.
 */
`default_nettype none
package i2cis_pkg;
	// ------------------------------------------------------------
	// register addresses
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_DATA_COMMAND_PORT = 32'h50001310;
	localparam logic [31:0] ADDR_BUS_INT_STATUS    = 32'h5000132C;
	localparam logic [31:0] ADDR_INT_MASK          = 32'h50001330;
	localparam logic [31:0] ADDR_RAW_STATUS        = 32'h50001334;
	localparam logic [31:0] ADDR_RX_THRESHOLD      = 32'h50001338;
	localparam logic [31:0] ADDR_TX_THRESHOLD      = 32'h5000133C;
	localparam logic [31:0] ADDR_ALL_FLAGS_CLEAR   = 32'h50001340;
	localparam logic [31:0] ADDR_READ_REQ_CLEAR    = 32'h50001350;
	localparam logic [31:0] ADDR_ABORT_CLEAR       = 32'h50001354;
	localparam logic [31:0] ADDR_ACTIVITY_CLEAR    = 32'h5000135C;
	localparam logic [31:0] ADDR_BROADCAST_CLEAR   = 32'h50001368;
	localparam logic [31:0] ADDR_CONTROLLER_ENABLE = 32'h5000136C;
	localparam logic [31:0] ADDR_ABORT_REASON      = 32'h50001380;

	// ------------------------------------------------------------
	// status bit positions
	// ------------------------------------------------------------
	localparam int BIT_RX_UNDER  = 0;
	localparam int BIT_RX_OVER   = 1;
	localparam int BIT_RX_FULL   = 2;
	localparam int BIT_TX_OVER   = 3;
	localparam int BIT_TX_EMPTY  = 4;
	localparam int BIT_RD_REQ    = 5;
	localparam int BIT_TX_ABORT  = 6;
	localparam int BIT_RX_DONE   = 7;
	localparam int BIT_ACTIVITY  = 8;
	localparam int BIT_STOP      = 9;
	localparam int BIT_START     = 10;
	localparam int BIT_BROADCAST = 11;
	localparam int ENABLE_BIT    = 0;

	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int STAT_W = 16;
	localparam int PTR_W  = 5;
	localparam int LVL_W  = 6;
	localparam int DATA_W = 8;
	localparam int CMD_W  = 9;
	localparam int THR_W  = 8;
	localparam int FIFO_DEPTH = 32;
	localparam logic [15:0] MASK_RESET  = 16'h08FF;
	localparam logic [15:0] STAT_RESET  = 16'h0000;
	localparam logic [15:0] STICKY_BITS = 16'h0FEB;
	localparam logic [5:0]  LVL_FULL    = 6'h20;
	localparam logic [5:0]  LVL_EMPTY   = 6'h00;
	localparam logic [5:0]  LVL_ONE     = 6'h01;
	localparam logic [4:0]  PTR_ONE     = 5'h01;

	// enable modes: off, running, disabled but still draining
	typedef enum logic [1:0] {
		EN_OFF   = 2'h0,
		EN_ON    = 2'h1,
		EN_DRAIN = 2'h3
	} i2cis_en_state_t;
endpackage
`default_nettype wire

//--- i2cis_bus_watch.sv
/*
 * Bus condition watcher: synchronises the clock and data lines and
 * reports START and STOP conditions as one-cycle pulses.
 * Assumes the pins are asynchronous to clk and far slower than it.
 */
`timescale 1ns/1ns
`default_nettype none
module i2cis_bus_watch (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// bus pins
	input  wire logic sclIn,
	input  wire logic sdaIn,
	// detected conditions
	output logic      startSeen,
	output logic      stopSeen
);
	typedef struct packed {
		logic sclMeta;
		logic sdaMeta;
		logic sclSync;
		logic sdaSync;
		logic sclLast;
		logic sdaLast;
		logic start;
		logic stop;
	} i2cis_watch_t;

	i2cis_watch_t s_reg;
	i2cis_watch_t s_next;

	// ------------------------------------------------------------
	// sync chain and edge detection
	// ------------------------------------------------------------
	// only the second stage and later feed the detectors
	always_comb begin
		s_next = s_reg;
		s_next.sclMeta = sclIn;
		s_next.sdaMeta = sdaIn;
		s_next.sclSync = s_reg.sclMeta;
		s_next.sdaSync = s_reg.sdaMeta;
		s_next.sclLast = s_reg.sclSync;
		s_next.sdaLast = s_reg.sdaSync;
		// data falls while clock stays high
		s_next.start = s_reg.sclSync & s_reg.sclLast & s_reg.sdaLast & ~s_reg.sdaSync;
		// data rises while clock stays high
		s_next.stop = s_reg.sclSync & s_reg.sclLast & ~s_reg.sdaLast & s_reg.sdaSync;
	end

	// idle bus is high on both lines
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '{sclMeta: 1'b1, sdaMeta: 1'b1, sclSync: 1'b1, sdaSync: 1'b1,
				sclLast: 1'b1, sdaLast: 1'b1, start: 1'b0, stop: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign startSeen = s_reg.start;
	assign stopSeen  = s_reg.stop;
endmodule
`default_nettype wire

//--- i2cis_fifo_mem.sv
/*
 * Small FIFO storage: one write port, one registered read port.
 * Assumes the caller keeps pointers and never writes a full store.
 */
`timescale 1ns/1ns
`default_nettype none
module i2cis_fifo_mem #(
	parameter int W     = 8,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          reset_n,
	// write side
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [W-1:0]  wrData,
	// read side
	input  wire logic [AW-1:0] rdAddr,
	output logic      [W-1:0]  rdData
);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [W-1:0]            rdData;
	} i2cis_mem_t;

	i2cis_mem_t s_reg;
	i2cis_mem_t s_next;

	// bypass keeps the head valid when writing into an empty store
	always_comb begin
		s_next = s_reg;
		if (wrEn) begin
			s_next.mem[wrAddr] = wrData;
		end
		s_next.rdData = (wrEn && wrAddr == rdAddr) ? wrData : s_reg.mem[rdAddr];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rdData = s_reg.rdData;
endmodule
`default_nettype wire

//--- i2cis_status_logic.sv
/*
 * Interrupt status logic of a two-wire controller: sticky event flags,
 * FIFO level flags, clear-on-read registers, mask, interrupt output,
 * transmit and receive FIFOs, and the disable/drain behaviour.
 * Assumes a protocol core on clk reporting events as one-cycle pulses,
 * and bus pins arriving asynchronously.
 */
`timescale 1ns/1ns
`default_nettype none
module i2cis_status_logic (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// register port
	input  wire logic        regRead,
	input  wire logic        regWrite,
	input  wire logic [31:0] regAddr,
	input  wire logic [31:0] regWdata,
	output logic      [31:0] regRdata,
	// bus pins
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sclOut,
	output logic             sclOe,
	// protocol core events
	input  wire logic        coreActive,
	input  wire logic        slaveNackPulse,
	input  wire logic        txAbortPulse,
	input  wire logic [15:0] abortReasonIn,
	input  wire logic        readRequestPulse,
	input  wire logic        broadcastPulse,
	input  wire logic        rxByteValid,
	input  wire logic [7:0]  rxByte,
	// transmit queue towards the core
	input  wire logic        txPopReq,
	output logic             txValid,
	output logic      [8:0]  txHead,
	// status
	output logic             internalEnableSignal,
	output logic             interruptOut
);
	typedef struct packed {
		i2cis_pkg::i2cis_en_state_t mode;
		logic                       enableBit;
		logic [15:0]                mask;
		logic [7:0]                 txThr;
		logic [7:0]                 rxThr;
		logic [15:0]                flags;
		logic [15:0]                abortReason;
		logic [4:0]                 txWr;
		logic [4:0]                 txRd;
		logic [5:0]                 txLvl;
		logic [4:0]                 rxWr;
		logic [4:0]                 rxRd;
		logic [5:0]                 rxLvl;
		logic [31:0]                rdata;
		logic                       irq;
	} i2cis_state_t;

	localparam i2cis_state_t RESET_STATE = '{mode: i2cis_pkg::EN_OFF,
		mask: i2cis_pkg::MASK_RESET, flags: i2cis_pkg::STAT_RESET, default: '0};

	i2cis_state_t s_reg;
	i2cis_state_t s_next;

	logic        startSeen;
	logic        stopSeen;
	logic [7:0]  rxHead;
	logic [15:0] statRaw;
	logic [15:0] flagSet;
	logic [15:0] flagClr;
	logic [31:0] readValue;
	logic        rdCmd;
	logic        wrCmd;
	logic        txFlush;
	logic        rxFlush;
	logic        txPush;
	logic        txPop;
	logic        rxPush;
	logic        rxPop;
	logic        clrAll;
	logic        txEmptyLvl;
	logic        rxFullLvl;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	function automatic logic hit(input logic strobe, input logic [31:0] a,
		input logic [31:0] k);
		hit = strobe && (a == k);
	endfunction

	assign rdCmd  = hit(regRead, regAddr, i2cis_pkg::ADDR_DATA_COMMAND_PORT);
	assign wrCmd  = hit(regWrite, regAddr, i2cis_pkg::ADDR_DATA_COMMAND_PORT);
	assign clrAll = hit(regRead, regAddr, i2cis_pkg::ADDR_ALL_FLAGS_CLEAR);

	// ------------------------------------------------------------
	// FIFO control
	// ------------------------------------------------------------
	// abort keeps the queue flushed so stale commands never reach the bus
	assign txFlush = !s_reg.enableBit || s_reg.flags[i2cis_pkg::BIT_TX_ABORT];
	assign rxFlush = !s_reg.enableBit;
	assign txPush  = wrCmd && s_reg.txLvl != i2cis_pkg::LVL_FULL && !txFlush;
	assign txPop   = txPopReq && txValid && !txFlush;
	// a byte into a full store is acked by the core but dropped here
	assign rxPush  = rxByteValid && s_reg.rxLvl != i2cis_pkg::LVL_FULL && !rxFlush;
	assign rxPop   = rdCmd && s_reg.rxLvl != i2cis_pkg::LVL_EMPTY;
	assign txValid = s_reg.txLvl != i2cis_pkg::LVL_EMPTY && !txFlush;

	// level flags follow the FIFOs; disabled transmit side mirrors activity
	assign txEmptyLvl = s_reg.enableBit ? ({2'h0, s_reg.txLvl} <= s_reg.txThr)
		: coreActive;
	assign rxFullLvl  = s_reg.enableBit && ({2'h0, s_reg.rxLvl} >= s_reg.rxThr);

	// ------------------------------------------------------------
	// flag set and clear terms
	// ------------------------------------------------------------
	always_comb begin
		flagSet = '0;
		flagClr = {16{clrAll}};
		flagSet[i2cis_pkg::BIT_START]     = startSeen;
		flagSet[i2cis_pkg::BIT_STOP]      = stopSeen;
		flagSet[i2cis_pkg::BIT_ACTIVITY]  = coreActive;
		flagSet[i2cis_pkg::BIT_RX_DONE]   = slaveNackPulse;
		flagSet[i2cis_pkg::BIT_TX_ABORT]  = txAbortPulse;
		flagSet[i2cis_pkg::BIT_RD_REQ]    = readRequestPulse;
		flagSet[i2cis_pkg::BIT_TX_OVER]   = wrCmd && s_reg.txLvl == i2cis_pkg::LVL_FULL;
		flagSet[i2cis_pkg::BIT_RX_OVER]   = rxByteValid && s_reg.rxLvl == i2cis_pkg::LVL_FULL;
		flagSet[i2cis_pkg::BIT_RX_UNDER]  = rdCmd && s_reg.rxLvl == i2cis_pkg::LVL_EMPTY;
		flagSet[i2cis_pkg::BIT_BROADCAST] = broadcastPulse && s_reg.enableBit;
		// activity clears on disable or either clear register
		flagClr[i2cis_pkg::BIT_ACTIVITY] = clrAll || !s_reg.enableBit
			|| hit(regRead, regAddr, i2cis_pkg::ADDR_ACTIVITY_CLEAR);
		flagClr[i2cis_pkg::BIT_TX_ABORT] = clrAll
			|| hit(regRead, regAddr, i2cis_pkg::ADDR_ABORT_CLEAR);
		flagClr[i2cis_pkg::BIT_RD_REQ] = clrAll
			|| hit(regRead, regAddr, i2cis_pkg::ADDR_READ_REQ_CLEAR);
		flagClr[i2cis_pkg::BIT_BROADCAST] = clrAll || !s_reg.enableBit
			|| hit(regRead, regAddr, i2cis_pkg::ADDR_BROADCAST_CLEAR);
		// error flags survive the drain, drop once internal enable is low
		flagClr[i2cis_pkg::BIT_TX_OVER]  = clrAll || s_reg.mode == i2cis_pkg::EN_OFF;
		flagClr[i2cis_pkg::BIT_RX_OVER]  = clrAll || s_reg.mode == i2cis_pkg::EN_OFF;
		flagClr[i2cis_pkg::BIT_RX_UNDER] = clrAll || s_reg.mode == i2cis_pkg::EN_OFF;
	end

	// raw view: sticky flags plus live level flags, reserved bits zero
	always_comb begin
		statRaw = s_reg.flags & i2cis_pkg::STICKY_BITS;
		statRaw[i2cis_pkg::BIT_TX_EMPTY] = txEmptyLvl;
		statRaw[i2cis_pkg::BIT_RX_FULL]  = rxFullLvl;
	end

	// ------------------------------------------------------------
	// register read mux
	// ------------------------------------------------------------
	always_comb begin
		case (regAddr)
			i2cis_pkg::ADDR_BUS_INT_STATUS:    readValue = {16'h0000, statRaw & s_reg.mask};
			i2cis_pkg::ADDR_RAW_STATUS:        readValue = {16'h0000, statRaw};
			i2cis_pkg::ADDR_INT_MASK:          readValue = {16'h0000, s_reg.mask};
			i2cis_pkg::ADDR_CONTROLLER_ENABLE: readValue = {31'h00000000, s_reg.enableBit};
			i2cis_pkg::ADDR_TX_THRESHOLD:      readValue = {24'h000000, s_reg.txThr};
			i2cis_pkg::ADDR_RX_THRESHOLD:      readValue = {24'h000000, s_reg.rxThr};
			i2cis_pkg::ADDR_DATA_COMMAND_PORT: readValue = {24'h000000, rxHead};
			i2cis_pkg::ADDR_ABORT_REASON:      readValue = {16'h0000, s_reg.abortReason};
			default:                           readValue = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		if (hit(regWrite, regAddr, i2cis_pkg::ADDR_CONTROLLER_ENABLE)) begin
			s_next.enableBit = regWdata[i2cis_pkg::ENABLE_BIT];
		end
		if (hit(regWrite, regAddr, i2cis_pkg::ADDR_INT_MASK)) begin
			s_next.mask = regWdata[15:0];
		end
		if (hit(regWrite, regAddr, i2cis_pkg::ADDR_TX_THRESHOLD)) begin
			s_next.txThr = regWdata[7:0];
		end
		if (hit(regWrite, regAddr, i2cis_pkg::ADDR_RX_THRESHOLD)) begin
			s_next.rxThr = regWdata[7:0];
		end
		// internal enable lags a disable until the core goes idle
		case (s_reg.mode)
			i2cis_pkg::EN_OFF: begin
				if (s_reg.enableBit) s_next.mode = i2cis_pkg::EN_ON;
			end
			i2cis_pkg::EN_ON: begin
				if (!s_reg.enableBit) begin
					s_next.mode = coreActive ? i2cis_pkg::EN_DRAIN : i2cis_pkg::EN_OFF;
				end
			end
			i2cis_pkg::EN_DRAIN: begin
				if (s_reg.enableBit) s_next.mode = i2cis_pkg::EN_ON;
				else if (!coreActive) s_next.mode = i2cis_pkg::EN_OFF;
			end
			default: s_next.mode = i2cis_pkg::EN_OFF;
		endcase
		// transmit pointers
		if (txFlush) begin
			s_next.txWr  = '0;
			s_next.txRd  = '0;
			s_next.txLvl = i2cis_pkg::LVL_EMPTY;
		end else begin
			if (txPush) s_next.txWr = s_reg.txWr + i2cis_pkg::PTR_ONE;
			if (txPop) s_next.txRd = s_reg.txRd + i2cis_pkg::PTR_ONE;
			if (txPush && !txPop) s_next.txLvl = s_reg.txLvl + i2cis_pkg::LVL_ONE;
			if (txPop && !txPush) s_next.txLvl = s_reg.txLvl - i2cis_pkg::LVL_ONE;
		end
		// receive pointers
		if (rxFlush) begin
			s_next.rxWr  = '0;
			s_next.rxRd  = '0;
			s_next.rxLvl = i2cis_pkg::LVL_EMPTY;
		end else begin
			if (rxPush) s_next.rxWr = s_reg.rxWr + i2cis_pkg::PTR_ONE;
			if (rxPop) s_next.rxRd = s_reg.rxRd + i2cis_pkg::PTR_ONE;
			if (rxPush && !rxPop) s_next.rxLvl = s_reg.rxLvl + i2cis_pkg::LVL_ONE;
			if (rxPop && !rxPush) s_next.rxLvl = s_reg.rxLvl - i2cis_pkg::LVL_ONE;
		end
		// set wins over a clear in the same cycle
		s_next.flags = flagSet | (s_reg.flags & ~flagClr);
		// reason is dropped with the abort flag, a new abort recaptures it
		if (flagClr[i2cis_pkg::BIT_TX_ABORT]) s_next.abortReason = '0;
		if (txAbortPulse) s_next.abortReason = abortReasonIn;
		if (regRead) s_next.rdata = readValue;
		s_next.irq = |(statRaw & s_reg.mask);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_reg <= RESET_STATE;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// submodules and outputs
	// ------------------------------------------------------------
	i2cis_bus_watch uWatch (
		.clk       (clk),
		.reset_n   (reset_n),
		.sclIn     (sclIn),
		.sdaIn     (sdaIn),
		.startSeen (startSeen),
		.stopSeen  (stopSeen)
	);

	i2cis_fifo_mem #(.W(i2cis_pkg::CMD_W), .DEPTH(i2cis_pkg::FIFO_DEPTH),
		.AW(i2cis_pkg::PTR_W)) uTxMem (
		.clk    (clk),
		.reset_n(reset_n),
		.wrEn   (txPush),
		.wrAddr (s_reg.txWr),
		.wrData (regWdata[8:0]),
		.rdAddr (s_next.txRd),
		.rdData (txHead)
	);

	i2cis_fifo_mem #(.W(i2cis_pkg::DATA_W), .DEPTH(i2cis_pkg::FIFO_DEPTH),
		.AW(i2cis_pkg::PTR_W)) uRxMem (
		.clk    (clk),
		.reset_n(reset_n),
		.wrEn   (rxPush),
		.wrAddr (s_reg.rxWr),
		.wrData (rxByte),
		.rdAddr (s_next.rxRd),
		.rdData (rxHead)
	);

	assign regRdata = s_reg.rdata;
	assign interruptOut = s_reg.irq;
	assign internalEnableSignal = s_reg.mode != i2cis_pkg::EN_OFF;
	// stretch the clock low while a read request waits
	assign sclOut = 1'b0;
	assign sclOe  = s_reg.flags[i2cis_pkg::BIT_RD_REQ];

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_start;
		startSeen |=> s_reg.flags[i2cis_pkg::BIT_START];
	endproperty
	a_start: assert property (p_start) else $error("start flag missed");

	property p_stop;
		stopSeen |=> s_reg.flags[i2cis_pkg::BIT_STOP]
			##1 (s_reg.flags[i2cis_pkg::BIT_STOP] || $past(clrAll));
	endproperty
	a_stop: assert property (p_stop) else $error("stop flag missed");

	property p_act_hold;
		s_reg.flags[i2cis_pkg::BIT_ACTIVITY] && !flagClr[i2cis_pkg::BIT_ACTIVITY]
			|=> s_reg.flags[i2cis_pkg::BIT_ACTIVITY];
	endproperty
	a_act_hold: assert property (p_act_hold) else $error("activity lost");

	property p_act_clear;
		$fell(s_reg.flags[i2cis_pkg::BIT_ACTIVITY]) |-> $past(flagClr[i2cis_pkg::BIT_ACTIVITY]);
	endproperty
	a_act_clear: assert property (p_act_clear) else $error("activity cleared");

	property p_abort_flush;
		s_reg.flags[i2cis_pkg::BIT_TX_ABORT] && s_reg.enableBit |=> s_reg.txLvl == 6'h00;
	endproperty
	a_abort_flush: assert property (p_abort_flush) else $error("fifo not flushed");

	property p_rdreq_stretch;
		readRequestPulse |=> sclOe && !sclOut;
	endproperty
	a_rdreq_stretch: assert property (p_rdreq_stretch) else $error("no stretch");

	property p_rdreq_clear;
		hit(regRead, regAddr, i2cis_pkg::ADDR_READ_REQ_CLEAR) && !readRequestPulse
			|=> !sclOe;
	endproperty
	a_rdreq_clear: assert property (p_rdreq_clear) else $error("read req kept");

	property p_tx_over;
		// a pop or flush in the same cycle legally moves the level; an abort only flushes a cycle later
		wrCmd && !txPop && !txFlush && !txAbortPulse && s_reg.txLvl == i2cis_pkg::LVL_FULL
			|=> s_reg.flags[i2cis_pkg::BIT_TX_OVER]
			&& s_reg.txLvl == i2cis_pkg::LVL_FULL;
	endproperty
	a_tx_over: assert property (p_tx_over) else $error("tx overflow missed");

	property p_rx_over;
		rxByteValid && !rxPop && s_reg.rxLvl == 6'h20 && s_reg.enableBit
			|=> s_reg.flags[i2cis_pkg::BIT_RX_OVER] && $stable(s_reg.rxLvl);
	endproperty
	a_rx_over: assert property (p_rx_over) else $error("rx overflow wrong");

	property p_rx_under;
		rdCmd && s_reg.rxLvl == 6'h00 |=> s_reg.flags[i2cis_pkg::BIT_RX_UNDER];
	endproperty
	a_rx_under: assert property (p_rx_under) else $error("underflow missed");

	property p_rx_full_off;
		hit(regWrite, regAddr, i2cis_pkg::ADDR_CONTROLLER_ENABLE)
			&& !regWdata[i2cis_pkg::ENABLE_BIT]
			|=> !statRaw[i2cis_pkg::BIT_RX_FULL] ##1 s_reg.rxLvl == i2cis_pkg::LVL_EMPTY;
	endproperty
	a_rx_full_off: assert property (p_rx_full_off) else $error("rx full kept");

	property p_irq;
		(statRaw & s_reg.mask) != 16'h0000 |=> interruptOut;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");

	c_abort: cover property (txAbortPulse ##1 s_reg.flags[i2cis_pkg::BIT_TX_ABORT]);
	c_rdreq: cover property (readRequestPulse ##[1:20] wrCmd);
	c_rxfull: cover property (s_reg.rxLvl == 6'h20 && rxByteValid);
	c_drain: cover property (s_reg.mode == i2cis_pkg::EN_DRAIN ##1 s_reg.mode == i2cis_pkg::EN_OFF);
endmodule
`default_nettype wire

//--- i2cis_bus_partner.sv
/* Far-side bus master model: a rising go sends START, two bits, STOP.
   Assumes pull-ups, so both lines idle high and the clock stands still. */
`timescale 1ns/1ns
`default_nettype none
module i2cis_bus_partner (
	// frame request
	input  wire logic go,
	// bus lines
	output logic      scl,
	output logic      sda
);
	// idle bus; 160 ns bit period inside a frame only
	initial begin
		scl = 1'b1;
		sda = 1'b1;
	end
	// data moves only while the clock is low, except at start and stop
	always @(posedge go) begin
		#40 sda = 1'b0;
		#40 scl = 1'b0;
		repeat (2) begin
			#40 sda = ~sda;
			#40 scl = 1'b1;
			#80 scl = 1'b0;
		end
		#40 sda = 1'b0;
		#40 scl = 1'b1;
		#80 sda = 1'b1;
	end
endmodule
`default_nettype wire

//--- i2cis_status_logic_tb_top.sv
/* Testbench top: drives register port, core events and bus frames.
   Assumes the package, the partner model and a 100 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module i2cis_status_logic_tb_top;
	logic        clk, reset_n, regRead, regWrite, coreActive, txPopReq;
	logic        rxByteValid, go, sclOut, sclOe, txValid, irq, pScl, sdaIn, ien;
	logic [4:0]  ev;
	logic [7:0]  rxByte;
	logic [8:0]  txHead;
	logic [15:0] abortReasonIn;
	logic [31:0] regAddr, regWdata, regRdata;
	int          n_fail, checks, cyc;
	wire         sclIn = pScl & ~sclOe;

	i2cis_status_logic dut (.clk, .reset_n, .regRead, .regWrite, .regAddr,
		.regWdata, .regRdata, .sclIn, .sdaIn, .sclOut, .sclOe, .coreActive,
		.slaveNackPulse(ev[0]), .txAbortPulse(ev[1]), .abortReasonIn,
		.readRequestPulse(ev[2]), .broadcastPulse(ev[3]), .rxByteValid, .rxByte,
		.txPopReq, .txValid, .txHead, .internalEnableSignal(ien), .interruptOut(irq));
	i2cis_bus_partner bfm (.go(go), .scl(pScl), .sda(sdaIn));

	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard: the sequence needs a few hundred cycles at most
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask
	// request held to the taking edge, data picked up once it lands
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk) begin
			regRead <= 1'b1;
			regAddr <= a;
		end
		@(posedge clk) regRead <= 1'b0;
		#1 d = regRdata;
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		@(posedge clk) begin
			regWrite <= 1'b1;
			regAddr  <= a;
			regWdata <= v;
		end
		@(posedge clk) regWrite <= 1'b0;
		#1;
	endtask
	task automatic bit_is(input int b, input logic e);
		logic [31:0] d;
		rd(i2cis_pkg::ADDR_RAW_STATUS, d);
		chk("raw status bit", 32'(e), 32'(d[b]));
	endtask
	task automatic pulse(input int i);
		@(posedge clk) ev[i] <= 1'b1;
		@(posedge clk) ev <= 5'h00;
	endtask
	function automatic logic [31:0] masked(input logic [31:0] r, input logic [31:0] k);
		return {16'h0, r[15:0] & k[15:0]};
	endfunction

	// main sequence; flags read back through the raw view
	initial begin
		logic [31:0] d, m, s;
		logic [7:0]  first;
		{reset_n, regRead, regWrite, coreActive, txPopReq, rxByteValid, go} = '0;
		{ev, rxByte, abortReasonIn, regAddr, regWdata} = '0;
		d = $urandom(47439);
		repeat (12) @(posedge clk);
		reset_n <= 1'b1;
		rd(i2cis_pkg::ADDR_INT_MASK, d);
		chk("mask", {16'h0, i2cis_pkg::MASK_RESET}, d);
		wr(i2cis_pkg::ADDR_BUS_INT_STATUS, 32'hFFFFFFFF);
		rd(i2cis_pkg::ADDR_BUS_INT_STATUS, d);
		chk("status", 32'h0, d);
		wr(i2cis_pkg::ADDR_RX_THRESHOLD, 32'h2);
		wr(i2cis_pkg::ADDR_CONTROLLER_ENABLE, 32'h1);
		bit_is(4, 1'b1);
		pulse(2);
		bit_is(5, 1'b1);
		chk("stretch", 32'h1, 32'(sclOe));
		chk("stretch drive", 32'h0, 32'(sclOut));
		wr(i2cis_pkg::ADDR_DATA_COMMAND_PORT, 32'hA5);
		rd(i2cis_pkg::ADDR_READ_REQ_CLEAR, d);
		bit_is(5, 1'b0);
		chk("stretch", 32'h0, 32'(sclOe));
		abortReasonIn <= 16'($urandom);
		pulse(1);
		bit_is(6, 1'b1);
		chk("tx valid", 32'h0, 32'(txValid));
		rd(i2cis_pkg::ADDR_ABORT_REASON, d);
		chk("reason", 32'(abortReasonIn), d);
		wr(i2cis_pkg::ADDR_DATA_COMMAND_PORT, 32'h3C);
		chk("tx valid", 32'h0, 32'(txValid));
		rd(i2cis_pkg::ADDR_ABORT_CLEAR, d);
		m = $urandom & 32'h1FF;
		wr(i2cis_pkg::ADDR_DATA_COMMAND_PORT, m);
		chk("tx valid", 32'h1, 32'(txValid));
		@(posedge clk) #1;
		chk("tx head", m, 32'(txHead));
		// second entry, then one pop: the head moves on to it
		s = $urandom & 32'h1FF;
		wr(i2cis_pkg::ADDR_DATA_COMMAND_PORT, s);
		@(posedge clk) txPopReq <= 1'b1;
		@(posedge clk) txPopReq <= 1'b0;
		#1 chk("tx head after pop", s, 32'(txHead));
		chk("tx valid", 32'h1, 32'(txValid));
		// fill to 32 entries, then one write too many
		for (int i = 0; i < 32; i++) begin
			if (i == 31) bit_is(3, 1'b0);
			wr(i2cis_pkg::ADDR_DATA_COMMAND_PORT, $urandom & 32'h1FF);
		end
		bit_is(3, 1'b1);
		bit_is(4, 1'b0);
		pulse(0);
		pulse(3);
		bit_is(7, 1'b1);
		bit_is(11, 1'b1);
		m = $urandom & 32'hFFFF;
		wr(i2cis_pkg::ADDR_INT_MASK, m);
		rd(i2cis_pkg::ADDR_RAW_STATUS, d);
		rd(i2cis_pkg::ADDR_BUS_INT_STATUS, s);
		chk("status", masked(d, m), s);
		chk("irq", 32'(|masked(d, m)), 32'(irq));
		rd(i2cis_pkg::ADDR_BROADCAST_CLEAR, d);
		bit_is(11, 1'b0);
		coreActive <= 1'b1;
		repeat (3) @(posedge clk);
		coreActive <= 1'b0;
		bit_is(8, 1'b1);
		rd(i2cis_pkg::ADDR_ACTIVITY_CLEAR, d);
		bit_is(8, 1'b0);
		coreActive <= 1'b1;
		repeat (3) @(posedge clk);
		coreActive <= 1'b0;
		rd(i2cis_pkg::ADDR_ALL_FLAGS_CLEAR, d);
		bit_is(8, 1'b0);
		go <= 1'b1;
		repeat (100) @(posedge clk);
		bit_is(10, 1'b1);
		bit_is(9, 1'b1);
		// 33 received bytes: the last one finds the store full
		for (int i = 0; i < 33; i++) begin
			m = $urandom;
			if (i == 0) first = m[7:0];
			@(posedge clk) begin
				rxByteValid <= 1'b1;
				rxByte      <= m[7:0];
			end
			@(posedge clk) rxByteValid <= 1'b0;
			if (i < 2) bit_is(2, i[0]);
		end
		bit_is(1, 1'b1);
		rd(i2cis_pkg::ADDR_DATA_COMMAND_PORT, d);
		chk("rx byte", 32'(first), d);
		coreActive <= 1'b1;
		wr(i2cis_pkg::ADDR_CONTROLLER_ENABLE, 32'h0);
		bit_is(2, 1'b0);
		bit_is(1, 1'b1);
		bit_is(4, 1'b1);
		chk("internal enable", 32'h1, 32'(ien));
		coreActive <= 1'b0;
		repeat (2) @(posedge clk);
		bit_is(1, 1'b0);
		bit_is(4, 1'b0);
		chk("internal enable", 32'h0, 32'(ien));
		wr(i2cis_pkg::ADDR_CONTROLLER_ENABLE, 32'h1);
		rd(i2cis_pkg::ADDR_DATA_COMMAND_PORT, d);
		bit_is(0, 1'b1);
		close_out();
	end
endmodule
`default_nettype wire
